// ### rtl/adc_serial_port_mode_select.sv
// Serial output port with mode select pins, master and chained slave shifting, Wishbone control.
`timescale 1ns/1ps
`include "serial_port_defs.svh"

module adc_serial_port_mode_select (
  // System clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial clock pin, two-way.
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_o,
  // Clock-invert pin, also parallel data bit 6.
  input wire logic serial_clock_invert_i,
  output logic serial_clock_invert_o,
  output logic serial_clock_invert_oe_o,
  // Read mode or chain input pin, also parallel data bit 7.
  input wire logic read_mode_or_chain_in_i,
  output logic read_mode_or_chain_in_o,
  output logic read_mode_or_chain_in_oe_o,
  // Serial read frame from the host in slave mode, active low.
  input wire logic read_select_n_i,
  // Serial data and frame sync outputs.
  output logic serial_data_out_o,
  output logic frame_sync_o
);
  import serial_port_pkg::*;

  logic [2:0] ctrl_reg;
  logic [31:0] next_result_reg;
  logic [31:0] result_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [2:0] inv_sync_reg;
  logic [2:0] rdm_sync_reg;
  logic [2:0] lbusy_sync_reg;
  logic invert_reg;
  logic read_mode_reg;
  logic link_busy_reg;
  logic converting_reg;
  logic [15:0] conv_cnt_reg;
  logic pending_reg;
  master_state_t m_state_reg;
  master_state_t m_state_next;
  logic [1:0] div_reg;
  logic sclk_int_reg;
  logic gap_half_reg;
  logic [4:0] bit_cnt_reg;
  logic [31:0] m_shift_reg;
  logic [31:0] s_shift_reg;
  logic s_sdo_reg;
  logic s_loaded_reg;
  logic [5:0] s_cnt_reg;
  logic link_active_reg;

  logic serial_mode;
  logic ext_clk;
  logic fsync_pol;
  logic wb_req;
  logic wr_ctrl;
  logic conv_start;
  logic conv_done;
  logic master_start;
  logic tick;
  logic fall_tick;
  logic link_clk;

  // Shift one bit in at the bottom; used by both shift engines.
  function automatic logic [31:0] shift_in(input logic [31:0] word, input logic bit_in);
    shift_in = {word[30:0], bit_in};
  endfunction

  assign serial_mode = ctrl_reg[`CTRL_SERIAL_BIT];
  assign ext_clk = ctrl_reg[`CTRL_EXT_CLK_BIT];
  assign fsync_pol = ctrl_reg[`CTRL_FSYNC_POL_BIT];
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_ctrl = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `REG_CTRL_OFS);

  // Bus answer one cycle after the request; unmapped offsets read zero and ignore writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else if (wb_req) begin
      case (wb_adr_i)
        `REG_CTRL_OFS: rdata_reg <= {29'h0, ctrl_reg};
        `REG_RESULT_OFS: rdata_reg <= next_result_reg;
        `REG_STATUS_OFS: rdata_reg <= {27'h0, invert_reg, read_mode_reg, link_busy_reg,
                                       (m_state_reg != M_IDLE), converting_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Control bits; the start bit is a write-only pulse and is not stored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RESET_VAL;
    end else if (wr_ctrl) begin
      ctrl_reg <= wb_dat_i[2:0];
    end
  end

  // Result the next conversion will produce, byte-lane writable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_result_reg <= 32'h0;
    end else if (wb_req && wb_we_i && (wb_adr_i == `REG_RESULT_OFS)) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          next_result_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
    end
  end

  // Pin inputs pass three flops; a change counts once the second and third agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inv_sync_reg <= 3'h0;
      rdm_sync_reg <= 3'h0;
      lbusy_sync_reg <= 3'h0;
      invert_reg <= 1'b0;
      read_mode_reg <= 1'b0;
      link_busy_reg <= 1'b0;
    end else begin
      inv_sync_reg <= {inv_sync_reg[1:0], serial_clock_invert_i};
      rdm_sync_reg <= {rdm_sync_reg[1:0], read_mode_or_chain_in_i};
      lbusy_sync_reg <= {lbusy_sync_reg[1:0], link_active_reg};
      if (inv_sync_reg[1] == inv_sync_reg[2]) begin
        invert_reg <= inv_sync_reg[2];
      end
      if (rdm_sync_reg[1] == rdm_sync_reg[2]) begin
        read_mode_reg <= rdm_sync_reg[2];
      end
      if (lbusy_sync_reg[1] == lbusy_sync_reg[2]) begin
        link_busy_reg <= lbusy_sync_reg[2];
      end
    end
  end

  // Conversion timer; a start while converting is ignored.
  assign conv_start = wr_ctrl && wb_dat_i[`CTRL_START_BIT] && !converting_reg;
  assign conv_done = converting_reg && (conv_cnt_reg == 16'(`CONV_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converting_reg <= 1'b0;
      conv_cnt_reg <= 16'h0;
    end else if (conv_start) begin
      converting_reg <= 1'b1;
      conv_cnt_reg <= 16'h0;
    end else if (conv_done) begin
      converting_reg <= 1'b0;
    end else if (converting_reg) begin
      conv_cnt_reg <= conv_cnt_reg + 16'h1;
    end
  end

  // New result is held back while a slave frame reads, so the link sees a stable word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= 32'h0;
      pending_reg <= 1'b0;
    end else if ((conv_done || pending_reg) && !link_busy_reg) begin
      result_reg <= next_result_reg;
      pending_reg <= 1'b0;
    end else if (conv_done) begin
      pending_reg <= 1'b1;
    end
  end

  assign master_start = serial_mode && !ext_clk && (m_state_reg == M_IDLE) &&
                        (read_mode_reg ? conv_start : conv_done);

  // Internal serial clock divider, running only while a master read is under way.
  assign tick = (div_reg == 2'(`MASTER_HALF_CYCLES - 1));
  assign fall_tick = tick && sclk_int_reg && (m_state_reg == M_SHIFT);

  always_ff @(posedge clk_i) begin
    if (rst_i || m_state_reg == M_IDLE || tick) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || m_state_reg != M_SHIFT) begin
      sclk_int_reg <= 1'b0;
    end else if (tick) begin
      sclk_int_reg <= !sclk_int_reg;
    end
  end

  always_comb begin
    m_state_next = m_state_reg;
    case (m_state_reg)
      M_IDLE: begin
        if (master_start) begin
          m_state_next = M_SHIFT;
        end
      end
      M_SHIFT: begin
        if (fall_tick && bit_cnt_reg == `RESULT_LAST) begin
          m_state_next = M_IDLE;
        end else if (fall_tick && bit_cnt_reg == `RESULT_HALF_LAST) begin
          m_state_next = M_GAP;
        end
      end
      M_GAP: begin
        if (tick && gap_half_reg) begin
          m_state_next = M_SHIFT;
        end
      end
      default: m_state_next = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_state_reg <= M_IDLE;
    end else begin
      m_state_reg <= m_state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || m_state_reg != M_GAP) begin
      gap_half_reg <= 1'b0;
    end else if (tick) begin
      gap_half_reg <= 1'b1;
    end
  end

  // MSB-first shift; a new bit follows each falling internal edge, except that the second channel's first bit waits for the end of the gap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_shift_reg <= 32'h0;
      bit_cnt_reg <= 5'h0;
    end else if (master_start) begin
      m_shift_reg <= conv_done ? next_result_reg : result_reg; // Result_reg catches it only now.
      bit_cnt_reg <= 5'h0;
    end else if ((fall_tick && bit_cnt_reg != `RESULT_HALF_LAST &&
                  bit_cnt_reg != `RESULT_LAST) || (m_state_reg == M_GAP && tick && gap_half_reg)) begin
      m_shift_reg <= shift_in(m_shift_reg, 1'b0);
      bit_cnt_reg <= bit_cnt_reg + 5'h1;
    end
  end

  // Slave updates on rising edge unless inverted; host holds the invert pin still.
  assign link_clk = sclk_i ^ serial_clock_invert_i;

  // Frame state in the link domain; the frame's own select ends it, since the clock may stop.
  always_ff @(posedge link_clk or posedge read_select_n_i) begin
    if (read_select_n_i) begin
      s_loaded_reg <= 1'b0;
      link_active_reg <= 1'b0;
      s_cnt_reg <= 6'h0;
    end else begin
      s_loaded_reg <= 1'b1;
      link_active_reg <= 1'b1;
      if (s_cnt_reg != 6'h3f) begin
        s_cnt_reg <= s_cnt_reg + 6'h1;
      end
    end
  end

  // Chain input role with external clock.
  always_ff @(posedge link_clk) begin
    if (!s_loaded_reg) begin
      s_sdo_reg <= result_reg[`RESULT_MSB];
      s_shift_reg <= shift_in(result_reg, read_mode_or_chain_in_i);
    end else begin
      s_sdo_reg <= s_shift_reg[`RESULT_MSB];
      s_shift_reg <= shift_in(s_shift_reg, read_mode_or_chain_in_i);
    end
  end

  // Clock sense inverted on the master pin too.
  assign sclk_oe_o = serial_mode && !ext_clk;
  assign sclk_o = sclk_int_reg ^ invert_reg;
  assign serial_data_out_o = ext_clk ? s_sdo_reg : m_shift_reg[`RESULT_MSB];

  assign frame_sync_o = (serial_mode && !ext_clk && m_state_reg == M_SHIFT) ^ fsync_pol;

  // Parallel data bits 6 and 7.
  assign serial_clock_invert_oe_o = !serial_mode;
  assign read_mode_or_chain_in_oe_o = !serial_mode;
  assign serial_clock_invert_o = result_reg[`PAR_BIT6_POS];
  assign read_mode_or_chain_in_o = result_reg[`PAR_BIT7_POS];

endmodule

// ### rtl/serial_port_defs.svh
// Register offsets, field positions and timing constants of the serial port block.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// Register byte offsets on the Wishbone bus.
`define REG_CTRL_OFS 4'h0
`define REG_RESULT_OFS 4'h4
`define REG_STATUS_OFS 4'h8

// Control register fields.
`define CTRL_SERIAL_BIT 0
`define CTRL_EXT_CLK_BIT 1
`define CTRL_FSYNC_POL_BIT 2
`define CTRL_START_BIT 3
`define CTRL_RESET_VAL 3'h1

// Status register fields.
`define STAT_CONVERTING_BIT 0
`define STAT_MASTER_BUSY_BIT 1
`define STAT_LINK_BUSY_BIT 2
`define STAT_READ_MODE_BIT 3
`define STAT_CLK_INVERT_BIT 4

// Result word layout and parallel bits 6 and 7 of the first channel.
`define RESULT_MSB 31
`define RESULT_HALF_LAST 5'h0f
`define RESULT_LAST 5'h1f
`define PAR_BIT6_POS 22
`define PAR_BIT7_POS 23

// Timing: 125 MHz system clock.
`define CLK_PERIOD_PS 8000
`define CONV_TIME_NS 1600
`define CONV_CYCLES ((`CONV_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MASTER_HALF_CYCLES 2

`endif

// ### rtl/serial_port_pkg.sv
// Types shared by the serial port block.
package serial_port_pkg;

  // Master shift engine states.
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SHIFT = 2'b01,
    M_GAP = 2'b10
  } master_state_t;

endpackage

// ### test/serial_port_monitor.sv
// Port timing checker for the serial port block.
`timescale 1ns/1ps
module serial_port_monitor (
  // Clock, reset and link clock pin.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  // Wishbone side.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Serial side.
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic serial_clock_invert_i,
  input wire logic serial_clock_invert_oe_o,
  input wire logic read_mode_or_chain_in_oe_o,
  input wire logic read_select_n_i,
  input wire logic serial_data_out_o
);
  // All checks sample on the system clock.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // bus
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) // bus
    else $error("ack longer than one cycle");
  a_hole_zero: assert property (wb_ack_o && wb_adr_i == 4'hc |-> wb_dat_o == 32'h0) // bus
    else $error("unmapped read not zero");
  a_start_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> !wb_dat_o[3]) // bus
    else $error("start bit read back set");
  a_pins_paired: assert property (serial_clock_invert_oe_o == read_mode_or_chain_in_oe_o)
    else $error("parallel pin enables differ");
  a_parallel_quiet: assert property (serial_clock_invert_oe_o |-> !sclk_oe_o)
    else $error("serial clock driven in parallel mode");
  a_sclk_half: assert property (sclk_oe_o && $changed(sclk_o) |=> $stable(sclk_o))
    else $error("serial clock half period too short");
  a_master_fall: assert property (sclk_oe_o && $stable(sclk_oe_o) &&
    $changed(serial_data_out_o) |-> sclk_o == serial_clock_invert_i)
    else $error("master data changed off the falling edge");
  a_slave_edge: assert property (!sclk_oe_o && !serial_clock_invert_oe_o &&
    !read_select_n_i && $past(!read_select_n_i) && $changed(serial_data_out_o)
    |-> sclk_i != serial_clock_invert_i)
    else $error("slave data changed off the active edge");
endmodule

// ### test/host_serial_model.sv
// Host serial port: captures master reads and clocks chained slave reads.
`timescale 1ns/1ps
module host_serial_model (
  // Device lines seen by the host.
  input wire logic dev_sclk_i,
  input wire logic dev_data_i,
  input wire logic invert_i,
  input wire logic frame_active_i,
  // Host lines and captured words.
  output logic sclk_o,
  output logic frame_n_o,
  output logic chain_o,
  output logic [31:0] rx_o,
  output logic [63:0] srx_o
);
  initial begin
    sclk_o = 1'b0;
    frame_n_o = 1'b1;
    chain_o = 1'b0;
  end
  // Sample on the rising edge of the true clock while the frame is active.
  always @(posedge (dev_sclk_i ^ invert_i)) begin
    if (frame_active_i) begin
      rx_o <= {rx_o[30:0], dev_data_i};
    end
  end
  // Chained frame of 64 edges, idle clock held still.
  task automatic slave_read(input logic [31:0] chain_word);
    sclk_o = invert_i;
    #20 frame_n_o = 1'b0;
    #23;
    for (int k = 0; k < 64; k++) begin
      chain_o = chain_word[~k[4:0]];
      #15 sclk_o = ~invert_i;
      #15 sclk_o = invert_i;
      srx_o = {srx_o[62:0], dev_data_i};
    end
    #30 frame_n_o = 1'b1;
    chain_o = ~chain_o;
  endtask
endmodule

// ### test/tb.sv
// Self-checking bench of the serial port block with a host model.
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, w, seed, rx;
  logic [63:0] srx;
  logic sclk_o, sclk_oe, ci_o, ci_oe, rc_o, rc_oe, sdo, fs;
  logic inv, rdm, pol, host_sclk, frame_n, chain, fs_q;
  int err_total, total_checks, cycles, syncs, n;
  // Pin levels from every party's enable; the chain pin only in link mode.
  wire sclk_pin = sclk_oe ? sclk_o : host_sclk;
  wire inv_pin = ci_oe ? ci_o : inv;
  wire rc_pin = rc_oe ? rc_o : (sclk_oe ? rdm : chain);
  adc_serial_port_mode_select u_adc_serial_port_mode_select (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_i(sclk_pin), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe), .serial_clock_invert_i(inv_pin), .serial_clock_invert_o(ci_o),
    .serial_clock_invert_oe_o(ci_oe), .read_mode_or_chain_in_i(rc_pin),
    .read_mode_or_chain_in_o(rc_o), .read_mode_or_chain_in_oe_o(rc_oe),
    .read_select_n_i(frame_n), .serial_data_out_o(sdo), .frame_sync_o(fs));
  host_serial_model u_host_serial_model (
    .dev_sclk_i(sclk_pin), .dev_data_i(sdo), .invert_i(inv), .frame_active_i(fs ^ pol),
    .sclk_o(host_sclk), .frame_n_o(frame_n), .chain_o(chain), .rx_o(rx), .srx_o(srx));
  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Frame sync changes are counted, so a missing channel gap shows up.
  always @(posedge clk_i) begin
    fs_q <= fs;
    if (fs_q !== fs) begin
      syncs <= syncs + 1;
    end
  end
  // A hang ends the run as a failure.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 43'h0};
    {inv, rdm, pol, err_total, total_checks, cycles, syncs, n} = 0;
    seed = 32'h31;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    check(rd, 32'h1);
    wb(1'b1, 4'hc, 4'hf, seed);
    wb(1'b0, 4'hc, 4'hf, 32'h0);
    check(rd, 32'h0); // unmapped place
    seed = lfsr(seed);
    w = {seed[31:16], ~seed[15:0]};
    // Byte lanes of the result word land separately.
    wb(1'b1, 4'h4, 4'hc, seed);
    wb(1'b1, 4'h4, 4'h3, ~seed);
    wb(1'b0, 4'h4, 4'hf, 32'h0);
    check(rd, w);
    wb(1'b1, 4'h0, 4'hf, 32'h9);
    repeat (100) @(posedge clk_i);
    check(fs, 1'b0);
    repeat (260) @(posedge clk_i);
    check(rx, w);
    rdm <= 1'b1;
    pol <= 1'b1;
    wb(1'b1, 4'h0, 4'hf, 32'h5);
    check(fs, 1'b1);
    seed = lfsr(seed);
    wb(1'b1, 4'h4, 4'hf, seed);
    n = syncs;
    wb(1'b1, 4'h0, 4'hf, 32'hd);
    check(fs, 1'b0);
    repeat (140) @(posedge clk_i);
    check(rx, w);
    check(syncs - n, 4);
    w = seed;
    repeat (80) @(posedge clk_i);
    inv <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(sclk_o, 1'b1);
    wb(1'b0, 4'h8, 4'hf, 32'h0);
    check(rd[4:3], 2'b11);
    rdm <= 1'b0;
    wb(1'b1, 4'h0, 4'hf, 32'h3);
    check(sclk_oe, 1'b0);
    for (int i = 0; i < 2; i++) begin
      inv <= i[0];
      repeat (5) @(posedge clk_i);
      seed = lfsr(seed);
      u_host_serial_model.slave_read(seed);
      check(srx, {w, seed});
      @(posedge clk_i);
    end
    seed = lfsr(seed);
    wb(1'b1, 4'h4, 4'hf, seed);
    wb(1'b1, 4'h0, 4'hf, 32'h8);
    repeat (210) @(posedge clk_i);
    check({ci_oe, rc_oe, ci_o, rc_o}, {2'b11, seed[22], seed[23]});
    wrap_up();
  end
endmodule
bind adc_serial_port_mode_select serial_port_monitor u_serial_port_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .serial_clock_invert_i(serial_clock_invert_i),
  .serial_clock_invert_oe_o(serial_clock_invert_oe_o),
  .read_mode_or_chain_in_oe_o(read_mode_or_chain_in_oe_o),
  .read_select_n_i(read_select_n_i), .serial_data_out_o(serial_data_out_o));
